/* File: rtl/mdmx_core.sv */
// multiply, divide, decimal adjust and move exec block with ahb-lite slave
//
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`include "mdmx_cfg.svh"
module mdmx_core
(
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_nrst,
    // ahb-lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // configuration strap and status
    input  wire logic        i_src_mode_strap,
    output logic             o_busy,
    output logic             o_src_mode,
    output logic      [23:0] o_ext_addr
);
    mdmx_pkg::mdmx_state_t s_reg;
    mdmx_pkg::mdmx_state_t s_next;
    mdmx_exec_if           u_if ();
    logic                  accept;

    function automatic logic [15:0] add16(input logic [7:0]  a,
                                          input logic [15:0] b);
        return b + {8'h00, a};
    endfunction : add16

    function automatic logic [31:0] status_word(
        input mdmx_pkg::mdmx_state_t st);
        return {12'h000, st.bytes, st.states, st.mode_ok, st.bad, st.ovf,
                st.aux, st.carry, st.mode, st.done, st.busy};
    endfunction : status_word

    // helpers
    mdmx_alu u_alu
    (
        .x (u_if.alu)
    );

    mdmx_tmg u_tmg
    (
        .x (u_if.tmg)
    );

    assign u_if.op       = s_reg.op;
    assign u_if.loc1     = s_reg.loc1;
    assign u_if.loc2     = s_reg.loc2;
    assign u_if.src_mode = s_reg.mode;
    assign u_if.nwait    = s_reg.nwait;
    assign u_if.dst      = s_reg.opa;
    assign u_if.src      = s_reg.opb;
    assign u_if.carry_in = s_reg.carry;
    assign u_if.aux_in   = s_reg.aux;

    assign accept = i_hsel & i_htrans[1] & i_hready;

    always_comb
    begin
        s_next      = s_reg;
        s_next.sync = {s_reg.sync[1:0], i_src_mode_strap};

        // opcode mode capture after reset release
        if (!s_reg.mode_ok)
        begin
            if (s_reg.cnt < `MDMX_SETTLE)
                s_next.cnt = s_reg.cnt + 8'h01;
            else if (s_reg.sync[1] == s_reg.sync[2])
            begin
                s_next.mode    = s_reg.sync[2];
                s_next.mode_ok = 1'b1;
                s_next.cnt     = 8'h00;
            end
        end

        // bus slave
        if (s_reg.bus == mdmx_pkg::BUS_WAIT)
        begin
            s_next.bus    = mdmx_pkg::BUS_DONE;
            s_next.hready = 1'b1;
            if (s_reg.wr)
            begin
                if (!s_reg.busy)
                begin
                    case (s_reg.addr)
                        `MDMX_OFS_CTRL:
                        begin
                            s_next.op   = mdmx_pkg::mdmx_op_t'(
                                i_hwdata[`MDMX_CTRL_OP]);
                            s_next.loc1 = mdmx_pkg::mdmx_loc_t'(
                                i_hwdata[`MDMX_CTRL_LOC1]);
                            s_next.loc2 = mdmx_pkg::mdmx_loc_t'(
                                i_hwdata[`MDMX_CTRL_LOC2]);
                            if (i_hwdata[`MDMX_CTRL_GO] && s_reg.mode_ok)
                            begin
                                s_next.busy = 1'b1;
                                s_next.done = 1'b0;
                                s_next.bad  = 1'b0;
                                s_next.cnt  = 8'h01;
                            end
                        end
                        `MDMX_OFS_OPA:    s_next.opa    = i_hwdata;
                        `MDMX_OFS_OPB:    s_next.opb    = i_hwdata;
                        `MDMX_OFS_FLAGS:
                        begin
                            s_next.carry = i_hwdata[0];
                            s_next.aux   = i_hwdata[1];
                        end
                        `MDMX_OFS_DATA_POINTER:   s_next.data_pointer   = i_hwdata[15:0];
                        `MDMX_OFS_REGION: s_next.region = i_hwdata[7:0];
                        `MDMX_OFS_WAIT:   s_next.nwait  = i_hwdata[3:0];
                        default:          s_next.nwait  = s_reg.nwait;
                    endcase
                end
            end
            else
            begin
                case (s_reg.addr)
                    `MDMX_OFS_CTRL:
                        s_next.hrdata = {20'h00000, s_reg.loc2,
                                         s_reg.loc1, 3'h0, s_reg.op};
                    `MDMX_OFS_OPA:    s_next.hrdata = s_reg.opa;
                    `MDMX_OFS_OPB:    s_next.hrdata = s_reg.opb;
                    `MDMX_OFS_FLAGS:
                        s_next.hrdata = {30'h0, s_reg.aux,
                                         s_reg.carry};
                    `MDMX_OFS_DATA_POINTER:   s_next.hrdata = {16'h0000, s_reg.data_pointer};
                    `MDMX_OFS_REGION: s_next.hrdata = {24'h000000,
                                                       s_reg.region};
                    `MDMX_OFS_WAIT:   s_next.hrdata = {28'h0000000,
                                                       s_reg.nwait};
                    `MDMX_OFS_RESULT: s_next.hrdata = s_reg.result;
                    `MDMX_OFS_STATUS: s_next.hrdata = status_word(s_reg);
                    `MDMX_OFS_XADDR:  s_next.hrdata = {8'h00, s_reg.xaddr};
                    default:          s_next.hrdata = 32'h00000000;
                endcase
            end
        end
        else if (accept)
        begin
            s_next.bus    = mdmx_pkg::BUS_WAIT;
            s_next.hready = 1'b0;
            s_next.addr   = i_haddr[7:0];
            s_next.wr     = i_hwrite;
        end
        else
        begin
            s_next.bus    = mdmx_pkg::BUS_IDLE;
            s_next.hready = 1'b1;
        end

        // execution: busy for exactly the counted states, one cycle for an invalid op
        if (s_reg.busy)
        begin
            if (!u_if.valid)
            begin
                s_next.busy = 1'b0;
                s_next.bad  = 1'b1;
                s_next.done = 1'b1;
                s_next.cnt  = 8'h00;
            end
            else if (s_reg.cnt >= u_if.states)
            begin
                s_next.busy   = 1'b0;
                s_next.done   = 1'b1;
                s_next.cnt    = 8'h00;
                s_next.states = u_if.states;
                s_next.bytes  = u_if.bytes;
                s_next.result = u_if.result;
                s_next.carry  = u_if.carry_out;
                s_next.ovf    = u_if.ovf;
                case (s_reg.op)
                    mdmx_pkg::OP_CODE_DP:
                        s_next.xaddr = {8'h00,
                            add16(s_reg.opa[7:0], s_reg.data_pointer)};
                    mdmx_pkg::OP_CODE_PC:
                        s_next.xaddr = {8'h00,
                            add16(s_reg.opa[7:0], s_reg.opa[31:16])};
                    mdmx_pkg::OP_XRD_DP, mdmx_pkg::OP_XWR_DP:
                        s_next.xaddr = {s_reg.region, s_reg.data_pointer};
                    mdmx_pkg::OP_XRD_RI, mdmx_pkg::OP_XWR_RI:
                        s_next.xaddr = {s_reg.region, 8'h00,
                                        s_reg.opb[15:8]};
                    mdmx_pkg::OP_LD_PTR:
                        s_next.data_pointer  = s_reg.opb[15:0];
                    default:
                        s_next.xaddr = s_reg.xaddr;
                endcase
            end
            else
                s_next.cnt = s_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            s_reg        <= '0;
            s_reg.bus    <= mdmx_pkg::BUS_IDLE;
            s_reg.hready <= 1'b1;
            s_reg.op     <= mdmx_pkg::OP_MULT_AB;
            s_reg.loc1   <= mdmx_pkg::LOC_INT;
            s_reg.loc2   <= mdmx_pkg::LOC_INT;
            s_reg.region <= `MDMX_RST_REGION;
        end
        else
            s_reg <= s_next;
    end

    // outputs straight from state except o_hresp, tied low
    assign o_hrdata    = s_reg.hrdata;
    assign o_hreadyout = s_reg.hready;
    assign o_hresp     = 1'b0;
    assign o_busy      = s_reg.busy;
    assign o_src_mode  = s_reg.mode;
    assign o_ext_addr  = s_reg.xaddr;
endmodule : mdmx_core

/* File: pkg/mdmx_cfg.svh */
// offsets, field positions, reset values and timing counts of the exec block
`ifndef MDMX_CFG_SVH
`define MDMX_CFG_SVH
// register byte offsets
`define MDMX_OFS_CTRL    8'h00
`define MDMX_OFS_OPA     8'h04
`define MDMX_OFS_OPB     8'h08
`define MDMX_OFS_FLAGS   8'h0C
`define MDMX_OFS_DATA_POINTER    8'h10
`define MDMX_OFS_REGION  8'h14
`define MDMX_OFS_WAIT    8'h18
`define MDMX_OFS_RESULT  8'h1C
`define MDMX_OFS_STATUS  8'h20
`define MDMX_OFS_XADDR   8'h24
// control fields
`define MDMX_CTRL_GO     31
`define MDMX_CTRL_LOC1   9:8
`define MDMX_CTRL_LOC2   11:10
`define MDMX_CTRL_OP     4:0
// reset value and mode settle count
`define MDMX_RST_REGION  8'h01
`define MDMX_SETTLE      8'h03
// timing rows {bin bytes, bin states, src bytes, src states}
`define MDMX_T_MULT_AB   24'h105105
`define MDMX_T_MULT_B    24'h306205
`define MDMX_T_MULT_W    24'h30C20B
`define MDMX_T_DIVD_AB   24'h10A10A
`define MDMX_T_DIVD_B    24'h30B20A
`define MDMX_T_DIVD_W    24'h315214
`define MDMX_T_DEC_ADJ   24'h101101
`define MDMX_T_UPPER     24'h503402
`define MDMX_T_EXTEND    24'h302201
`define MDMX_T_CODE      24'h106106
`define MDMX_T_XRD_RI    24'h104105
`define MDMX_T_XRD_DP    24'h103103
`define MDMX_T_XWR       24'h104104
`define MDMX_T_DIR_DIR   24'h303303
`define MDMX_T_DIR_ACCUM 24'h202202
`define MDMX_T_LD_PTR    24'h302302
`define MDMX_T_BANK_IMM  24'h201302
`define MDMX_T_IND_STORE 24'h103204
// state penalties
`define MDMX_PEN_PORT    8'h01
`define MDMX_PEN_SFR     8'h02
`define MDMX_PEN_EXT1    8'h01
`define MDMX_PEN_EXT2    8'h02
`endif

/* File: pkg/mdmx_pkg.sv */
// types of the multiply, divide and move exec block
package mdmx_pkg;
    typedef enum logic [4:0] {
        OP_MULT_AB = 5'h00, OP_MULT_B = 5'h01, OP_MULT_W = 5'h02,
        OP_DIVD_AB = 5'h03, OP_DIVD_B = 5'h04, OP_DIVD_W = 5'h05,
        OP_DEC_ADJ = 5'h06, OP_UPPER_WORD = 5'h07, OP_SIGN_EXT = 5'h08,
        OP_ZERO_EXT = 5'h09, OP_CODE_DP = 5'h0A, OP_CODE_PC = 5'h0B,
        OP_XRD_RI = 5'h0C, OP_XRD_DP = 5'h0D, OP_XWR_RI = 5'h0E,
        OP_XWR_DP = 5'h0F, OP_DIR_DIR = 5'h10, OP_DIR_ACCUM = 5'h11,
        OP_LD_PTR = 5'h12, OP_BANK_IMM = 5'h13, OP_IND_STORE = 5'h14
    } mdmx_op_t;
    typedef enum logic [1:0] {
        LOC_INT = 2'h0, LOC_EXT = 2'h1, LOC_PORT = 2'h2, LOC_SFR = 2'h3
    } mdmx_loc_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0, BUS_WAIT = 2'h1, BUS_DONE = 2'h2
    } mdmx_bus_t;
    typedef struct packed {
        mdmx_bus_t   bus;
        logic [7:0]  addr;
        logic        wr;
        logic        hready;
        logic [31:0] hrdata;
        mdmx_op_t    op;
        mdmx_loc_t   loc1;
        mdmx_loc_t   loc2;
        logic [31:0] opa;
        logic [31:0] opb;
        logic [31:0] result;
        logic [15:0] data_pointer;
        logic [7:0]  region;
        logic [3:0]  nwait;
        logic        carry;
        logic        aux;
        logic        ovf;
        logic        bad;
        logic        done;
        logic        busy;
        logic [7:0]  cnt;
        logic [7:0]  states;
        logic [3:0]  bytes;
        logic [2:0]  sync;
        logic        mode;
        logic        mode_ok;
        logic [23:0] xaddr;
    } mdmx_state_t;
endpackage : mdmx_pkg

/* File: pkg/mdmx_exec_if.sv */
// operand and timing carrier between the exec core and its helpers
interface mdmx_exec_if;
    mdmx_pkg::mdmx_op_t  op;
    mdmx_pkg::mdmx_loc_t loc1;
    mdmx_pkg::mdmx_loc_t loc2;
    logic                src_mode;
    logic [3:0]          nwait;
    logic [31:0]         dst;
    logic [31:0]         src;
    logic                carry_in;
    logic                aux_in;
    logic [31:0]         result;
    logic                carry_out;
    logic                ovf;
    logic [7:0]          states;
    logic [3:0]          bytes;
    logic                valid;
    modport core (output op, loc1, loc2, src_mode, nwait, dst, src,
                  carry_in, aux_in,
                  input result, carry_out, ovf, states, bytes, valid);
    modport alu  (input op, dst, src, carry_in, aux_in,
                  output result, carry_out, ovf);
    modport tmg  (input op, loc1, loc2, src_mode, nwait,
                  output states, bytes, valid);
endinterface : mdmx_exec_if

/* File: rtl/mdmx_alu.sv */
// arithmetic and move data path of the exec block
module mdmx_alu
(
    // operands and results
    mdmx_exec_if.alu x
);
    logic [15:0] prod8;
    logic [31:0] q8;
    logic [31:0] q16;
    logic [8:0]  adj;

    function automatic logic [31:0] divide16(input logic [15:0] n,
                                             input logic [15:0] d);
        if (d == 16'h0000)
            return {16'hFFFF, n};
        return {n / d, n % d};
    endfunction : divide16

    always_comb
    begin
        prod8       = {8'h00, x.dst[7:0]} * {8'h00, x.src[7:0]};
        q8          = divide16({8'h00, x.dst[7:0]}, {8'h00, x.src[7:0]});
        q16         = divide16(x.dst[15:0], x.src[15:0]);
        adj         = {1'b0, x.dst[7:0]};
        x.result    = x.src;
        x.carry_out = x.carry_in;
        x.ovf       = 1'b0;
        case (x.op)
            mdmx_pkg::OP_MULT_AB, mdmx_pkg::OP_MULT_B:
            begin
                x.result    = {16'h0000, prod8};
                x.carry_out = 1'b0;
                x.ovf       = |prod8[15:8];
            end
            mdmx_pkg::OP_MULT_W:
            begin
                x.result    = {16'h0000, x.dst[15:0]} *
                              {16'h0000, x.src[15:0]};
                x.carry_out = 1'b0;
                x.ovf       = |x.result[31:16];
            end
            mdmx_pkg::OP_DIVD_AB:
            begin
                x.result    = {16'h0000, q8[7:0], q8[23:16]};
                x.carry_out = 1'b0;
                x.ovf       = (x.src[7:0] == 8'h00);
            end
            mdmx_pkg::OP_DIVD_B:
            begin
                x.result    = {16'h0000, q8[23:16], q8[7:0]};
                x.carry_out = 1'b0;
                x.ovf       = (x.src[7:0] == 8'h00);
            end
            mdmx_pkg::OP_DIVD_W:
            begin
                x.result    = q16;
                x.carry_out = 1'b0;
                x.ovf       = (x.src[15:0] == 16'h0000);
            end
            mdmx_pkg::OP_DEC_ADJ:
            begin
                if (x.dst[3:0] > 4'h9 || x.aux_in)
                    adj = adj + 9'h006;
                if (adj[7:4] > 4'h9 || x.carry_in || adj[8])
                    adj = adj + 9'h060;
                x.result    = {x.dst[31:8], adj[7:0]};
                x.carry_out = x.carry_in | adj[8];
            end
            mdmx_pkg::OP_UPPER_WORD: x.result = {x.src[15:0], x.dst[15:0]};
            mdmx_pkg::OP_SIGN_EXT:
                x.result = {16'h0000, {8{x.src[7]}}, x.src[7:0]};
            mdmx_pkg::OP_ZERO_EXT:
                x.result = {16'h0000, 8'h00, x.src[7:0]};
            mdmx_pkg::OP_CODE_DP, mdmx_pkg::OP_CODE_PC,
            mdmx_pkg::OP_XRD_RI, mdmx_pkg::OP_XRD_DP:
                x.result = {x.dst[31:8], x.src[7:0]};
            mdmx_pkg::OP_XWR_RI, mdmx_pkg::OP_XWR_DP:
                x.result = x.dst;
            default: x.result = x.src;
        endcase
    end
endmodule : mdmx_alu

/* File: rtl/mdmx_tmg.sv */
// encoding length and state count of each exec operation
`include "mdmx_cfg.svh"
module mdmx_tmg
(
    // operation and cost
    mdmx_exec_if.tmg x
);
    logic [23:0] row;
    logic [7:0]  pen;

    function automatic logic [7:0] dir_pen(input mdmx_pkg::mdmx_loc_t l);
        case (l)
            mdmx_pkg::LOC_PORT: return `MDMX_PEN_PORT;
            mdmx_pkg::LOC_SFR:  return `MDMX_PEN_SFR;
            default:            return 8'h00;
        endcase
    endfunction : dir_pen

    always_comb
    begin
        row     = 24'h000000;
        x.valid = 1'b1;
        case (x.op)
            mdmx_pkg::OP_MULT_AB:    row = `MDMX_T_MULT_AB;
            mdmx_pkg::OP_MULT_B:     row = `MDMX_T_MULT_B;
            mdmx_pkg::OP_MULT_W:     row = `MDMX_T_MULT_W;
            mdmx_pkg::OP_DIVD_AB:    row = `MDMX_T_DIVD_AB;
            mdmx_pkg::OP_DIVD_B:     row = `MDMX_T_DIVD_B;
            mdmx_pkg::OP_DIVD_W:     row = `MDMX_T_DIVD_W;
            mdmx_pkg::OP_DEC_ADJ:    row = `MDMX_T_DEC_ADJ;
            mdmx_pkg::OP_UPPER_WORD: row = `MDMX_T_UPPER;
            mdmx_pkg::OP_SIGN_EXT:   row = `MDMX_T_EXTEND;
            mdmx_pkg::OP_ZERO_EXT:   row = `MDMX_T_EXTEND;
            mdmx_pkg::OP_CODE_DP:    row = `MDMX_T_CODE;
            mdmx_pkg::OP_CODE_PC:    row = `MDMX_T_CODE;
            mdmx_pkg::OP_XRD_RI:     row = `MDMX_T_XRD_RI;
            mdmx_pkg::OP_XRD_DP:     row = `MDMX_T_XRD_DP;
            mdmx_pkg::OP_XWR_RI:     row = `MDMX_T_XWR;
            mdmx_pkg::OP_XWR_DP:     row = `MDMX_T_XWR;
            mdmx_pkg::OP_DIR_DIR:    row = `MDMX_T_DIR_DIR;
            mdmx_pkg::OP_DIR_ACCUM:  row = `MDMX_T_DIR_ACCUM;
            mdmx_pkg::OP_LD_PTR:     row = `MDMX_T_LD_PTR;
            mdmx_pkg::OP_BANK_IMM:   row = `MDMX_T_BANK_IMM;
            mdmx_pkg::OP_IND_STORE:  row = `MDMX_T_IND_STORE;
            default:                 x.valid = 1'b0;
        endcase
        pen = 8'h00;
        case (x.op)
            mdmx_pkg::OP_CODE_DP, mdmx_pkg::OP_CODE_PC, mdmx_pkg::OP_XWR_DP:
                if (x.loc1 == mdmx_pkg::LOC_EXT)
                    pen = {4'h0, x.nwait} + `MDMX_PEN_EXT1;
            mdmx_pkg::OP_XRD_DP:
                if (x.loc1 == mdmx_pkg::LOC_EXT)
                    pen = {4'h0, x.nwait} + `MDMX_PEN_EXT2;
            mdmx_pkg::OP_DIR_DIR:
                pen = dir_pen(x.loc1) + dir_pen(x.loc2);
            mdmx_pkg::OP_DIR_ACCUM:
                pen = dir_pen(x.loc1);
            default: pen = 8'h00;
        endcase
        x.states = (x.src_mode ? row[7:0] : row[19:12]) + pen;
        x.bytes  = x.src_mode ? row[11:8] : row[23:20];
    end
endmodule : mdmx_tmg

/* File: dv/mdmx_core_monitor.sv */
// port assertions of the multiply, divide and move exec block
module mdmx_core_monitor
(
    // clock, reset and bus
    input wire logic        i_core_clk,
    input wire logic        i_nrst,
    input wire logic        i_hsel,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    // execution status
    input wire logic        o_busy,
    input wire logic        o_src_mode,
    input wire logic [23:0] o_ext_addr
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);
    a_resp_okay:
        assert property (o_hresp == 1'b0) else $error("response not okay");
    a_one_wait:
        assert property (i_hsel && i_htrans[1] && i_hready |=>
            !o_hreadyout ##1 o_hreadyout) else $error("wait state wrong");
    a_ready_idle:
        assert property (!(i_hsel && i_htrans[1]) && o_hreadyout |=>
            o_hreadyout) else $error("stall without transfer");
    a_rdata_hold:
        assert property (o_hreadyout && $past(o_hreadyout) |->
            $stable(o_hrdata)) else $error("read data moved");
    a_busy_bound:
        assert property ($rose(o_busy) |-> ##[1:40] !o_busy)
            else $error("busy too long");
    a_busy_cause:
        assert property ($rose(o_busy) |-> $past(!o_hreadyout))
            else $error("busy without a bus write");
    a_mode_fixed:
        assert property (o_busy |-> $stable(o_src_mode))
            else $error("mode changed while busy");
    a_addr_steady:
        assert property (o_busy && $past(o_busy) |-> $stable(o_ext_addr))
            else $error("address moved mid operation");
    cover property ($rose(o_busy));
    cover property ($fell(o_busy) && o_src_mode);
    cover property (!o_hreadyout ##1 o_hreadyout);
endmodule : mdmx_core_monitor

bind mdmx_core mdmx_core_monitor u_mon (.i_core_clk, .i_nrst, .i_hsel,
    .i_htrans, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .o_busy,
    .o_src_mode, .o_ext_addr);

/* File: dv/mdmx_ahb_host.sv */
// bus master model driving the exec block register port
module mdmx_ahb_host
(
    // clock and answer
    input  wire logic        i_core_clk,
    input  wire logic        i_hready,
    input  wire logic [31:0] i_hrdata,
    // request
    output logic             o_hsel,
    output logic      [31:0] o_haddr,
    output logic      [1:0]  o_htrans,
    output logic             o_hwrite,
    output logic      [2:0]  o_hsize,
    output logic      [31:0] o_hwdata
);
    initial
    begin
        o_hsel   = 1'b0;
        o_haddr  = 32'h0;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hsize  = 3'h2;
        o_hwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        o_hsel   <= 1'b1;
        o_htrans <= 2'h2;
        o_haddr  <= {24'h000000, a};
        o_hwrite <= w;
        do @(posedge i_core_clk); while (i_hready !== 1'b1);
        o_hsel   <= 1'b0;
        o_htrans <= 2'h0;
        o_hwdata <= d;
        do @(posedge i_core_clk); while (i_hready !== 1'b1);
        q = i_hrdata;
        o_hwdata <= ~d;
    endtask : xfer
endmodule : mdmx_ahb_host

/* File: dv/mdmx_core_tb_top.sv */
// self-checking bench of the exec block
`include "mdmx_cfg.svh"
module mdmx_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        nrst;
    logic        strap;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        busy;
    logic        mode;
    logic [23:0] xaddr;
    logic [31:0] q;
    int          failures;
    int          samples_checked;
    int          cyc;
    int          bc;
    int sb[21] = '{5,6,12,10,11,21,1,3,2,2,6,6,4,3,4,4,3,2,2,1,3};
    int ss[21] = '{5,5,11,10,10,20,1,2,1,1,6,6,5,3,4,4,3,2,2,2,4};
    int yb[21] = '{1,3,3,1,3,3,1,5,3,3,1,1,1,1,1,1,3,2,3,2,1};
    int ys[21] = '{1,2,2,1,2,2,1,4,2,2,1,1,1,1,1,1,3,2,3,3,2};
    mdmx_ahb_host host (.i_core_clk(clk), .i_hready(hready),
        .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
        .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
        .o_hwdata(hwdata));
    mdmx_core dut (.i_core_clk(clk), .i_nrst(nrst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_src_mode_strap(strap), .o_busy(busy), .o_src_mode(mode),
        .o_ext_addr(xaddr));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("failures %0d samples_checked %0d", failures,
                 samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (busy === 1'b1)
            bc <= bc + 1;
        if (cyc == 20000)
        begin
            failures = failures + 1;
            report_and_stop();
        end
    end
    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] s);
        samples_checked++;
        if (s !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, q);
    endtask : rd
    task automatic run(input logic [4:0] op, input logic [3:0] loc,
                       input logic [31:0] a, input logic [31:0] b);
        wr(`MDMX_OFS_OPA, a);
        wr(`MDMX_OFS_OPB, b);
        bc = 0;
        wr(`MDMX_OFS_CTRL, {1'b1, 19'h00000, loc, 3'h0, op});
        repeat (64) if (busy !== 1'b0) @(posedge clk);
        rd(`MDMX_OFS_STATUS);
    endtask : run
    task automatic cs(input int e, input int y);
        check("states", e, {24'h0, q[15:8]});
        check("busy cycles", e, bc);
        check("bytes", y, {28'h0, q[19:16]});
    endtask : cs
    task automatic do_reset(input logic s);
        strap <= s;
        nrst  <= 1'b0;
        repeat (16) @(posedge clk);
        nrst  <= 1'b1;
        q = 32'h0;
        repeat (64) if (q[7] !== 1'b1) rd(`MDMX_OFS_STATUS);
        check("mode ready", 32'h1, {31'h0, q[7]});
    endtask : do_reset
    task automatic t_timing(input logic s);
        int e;
        int y;
        for (int i = 0; i < 21; i++)
        begin
            run(5'(i), 4'h0, 32'h0, 32'h0);
            e = s ? ss[i] : sb[i];
            y = s ? ys[i] : yb[i];
            cs(e, y);
        end
    endtask : t_timing
    task automatic t_values();
        wr(`MDMX_OFS_FLAGS, 32'h0);
        run(5'h04, 4'h0, 32'h64, 32'h07);
        rd(`MDMX_OFS_RESULT);
        check("div", 32'h0E02, {16'h0, q[15:0]});
        run(5'h06, 4'h0, 32'h9A, 32'h0);
        check("da carry", 32'h1, {31'h0, q[3]});
        rd(`MDMX_OFS_RESULT);
        check("da", 32'h0, {24'h0, q[7:0]});
        run(5'h07, 4'h0, 32'h12345678, 32'hABCD);
        rd(`MDMX_OFS_RESULT);
        check("upper", 32'hABCD5678, q);
        run(5'h08, 4'h0, 32'h0, 32'h85);
        rd(`MDMX_OFS_RESULT);
        check("sext", 32'hFF85, {16'h0, q[15:0]});
        run(5'h09, 4'h0, 32'h0, 32'h85);
        rd(`MDMX_OFS_RESULT);
        check("zext", 32'h0085, {16'h0, q[15:0]});
        wr(`MDMX_OFS_DATA_POINTER, 32'h1000);
        run(5'h0A, 4'h0, 32'h10, 32'h0);
        check("code addr", 32'h001010, {8'h0, xaddr});
        run(5'h0B, 4'h0, 32'h20000010, 32'h0);
        check("pc addr", 32'h002010, {8'h0, xaddr});
    endtask : t_values
    task automatic t_external();
        wr(`MDMX_OFS_WAIT, 32'h3);
        rd(`MDMX_OFS_REGION);
        check("region", 32'h01, q);
        rd(8'h30);
        check("unmapped", 32'h0, q);
        run(5'h0D, 4'h1, 32'h0, 32'h0);
        cs(8, 1);
        check("xaddr", 32'h011000, {8'h0, xaddr});
        run(5'h0C, 4'h0, 32'h0, 32'h4200);
        cs(4, 1);
        check("ptr8 addr", 32'h010042, {8'h0, xaddr});
        run(5'h0A, 4'h1, 32'h0, 32'h0);
        cs(10, 1);
        run(5'h0F, 4'h1, 32'h0, 32'h0);
        cs(8, 1);
        run(5'h10, 4'hE, 32'h0, 32'h0);
        cs(6, 3);
        run(5'h11, 4'h3, 32'h0, 32'h0);
        cs(4, 2);
    endtask : t_external
    initial
    begin
        nrst = 1'b0;
        strap = 1'b0;
        cyc = 0;
        bc = 0;
        failures = 0;
        samples_checked = 0;
        @(posedge clk);
        do_reset(1'b0);
        t_timing(1'b0);
        t_values();
        t_external();
        do_reset(1'b1);
        check("mode", 32'h1, {31'h0, mode});
        strap <= 1'b0;
        t_timing(1'b1);
        check("mode held", 32'h1, {31'h0, mode});
        report_and_stop();
    end
endmodule : mdmx_core_tb_top
